// file: core/monitor_link.sv
`timescale 1ns/1ps
`default_nettype none
`include "monitor_params.svh"
module monitor_link #(
  parameter int BAUD_DIV = `MON_BAUD_DIV
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic por,
  // Entry pins
  input wire logic ext_reset_n,
  input wire logic irq_high_voltage,
  input wire logic rst_high_voltage,
  input wire logic divisor_select_pin,
  input wire logic reset_vector_blank,
  // Serial link pin
  input wire logic monitor_serial_pin_in,
  output logic monitor_serial_pin_out,
  output logic monitor_serial_pin_oe,
  // Clock and watchdog control
  output logic bus_clk_en,
  output logic [1:0] clk_div_sel,
  output logic watchdog_disable,
  output logic monitor_active,
  output logic extra_reset_req,
  output logic [7:0] vector_page,
  // Security
  output logic security_bypassed,
  output logic [7:0] security_flag_byte,
  output logic flash_read_invalid,
  input wire logic flash_fetch,
  output logic illegal_addr_reset,
  // Memory access
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic [15:0] stack_pointer,
  output logic cpu_entry_swi,
  output logic cpu_run
);
  typedef enum logic [3:0] {
    S_SEC, S_READY, S_CMD, S_ARG, S_ECHO, S_DATA, S_EXEC, S_CANCEL, S_BRKHI, S_BRKTX
  } st_t;
  // Synchronisers and reset edge capture
  logic [2:0] pin_s_q, rn_s_q, ihv_s_q, rhv_s_q;
  logic pin_f_q, rn_f_q, ihv_f_q, rhv_f_q;
  logic [2:0] pin_s_d, rn_s_d, ihv_s_d, rhv_s_d;
  logic pin_f_d, rn_f_d, ihv_f_d, rhv_f_d;
  monitor_pkg::mon_mode_t mode_q, mode_d;
  monitor_pkg::clk_div_t div_q, div_d;
  logic [1:0] dcnt_q, dcnt_d;
  logic ben_q, ben_d, wd_q, wd_d, xr_q, xr_d, xdone_q, xdone_d;
  // Command engine
  st_t st_q, st_d, ret_q, ret_d;
  logic [3:0] nbytes_q, nbytes_d, need_q, need_d;
  logic [7:0] cmd_q, cmd_d, byte_q, byte_d, tx_q, tx_d;
  logic [15:0] addr_q, addr_d, idx_q, idx_d;
  logic [3:0] bits_q, bits_d;
  logic sec_ok_q, sec_ok_d, sec_done_q, sec_done_d, tx_go_q, tx_go_d, tx_brk_q, tx_brk_d;
  logic mreq_q, mreq_d, mwe_q, mwe_d, run_q, run_d, swi_q, swi_d, ill_q, ill_d;
  logic [7:0] wdat_q, wdat_d;
  logic [15:0] maddr_q, maddr_d;
  logic pull_q, pull_d;
  logic rx_valid, rx_break, tx_busy, bit_tick, uart_pull;
  logic [7:0] rx_data;

  function automatic logic [3:0] cmd_args(input logic [7:0] c);
    unique case (c)
      `MON_CMD_READ: cmd_args = 4'h2;
      `MON_CMD_WRITE: cmd_args = 4'h3;
      `MON_CMD_INDEXED_WRITE_CMD: cmd_args = 4'h1;
      default: cmd_args = 4'h0;
    endcase
  endfunction : cmd_args

  function automatic logic is_read(input logic [7:0] c);
    is_read = (c == `MON_CMD_READ) || (c == `MON_CMD_INDEXED_READ_CMD) || (c == `MON_CMD_STACK_POINTER_READ_CMD);
  endfunction : is_read

  mon_uart #(.DIV(BAUD_DIV)) u_uart (
    .clk(clk),
    .rst(rst),
    .bus_en(ben_q),
    .line_in(pin_f_q),
    .pull_low(uart_pull),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_break(rx_break),
    .tx_start(tx_go_q),
    .tx_brk(tx_brk_q),
    .tx_data(tx_q),
    .tx_busy(tx_busy),
    .bit_tick(bit_tick)
  );

  assign monitor_serial_pin_out = 1'b0;
  assign monitor_serial_pin_oe = pull_q;
  assign bus_clk_en = ben_q;
  assign clk_div_sel = div_q;
  assign watchdog_disable = wd_q;
  assign monitor_active = mode_q != monitor_pkg::MODE_USER;
  assign extra_reset_req = xr_q;
  assign vector_page = (mode_q != monitor_pkg::MODE_USER) ? `MON_MON_VEC_PAGE
                                                          : `MON_USER_VEC_PAGE;
  assign security_bypassed = sec_ok_q;
  assign security_flag_byte = {1'b0, sec_ok_q, 6'h00};
  assign flash_read_invalid = !sec_ok_q;
  assign illegal_addr_reset = ill_q;
  assign mem_req = mreq_q;
  assign mem_we = mwe_q;
  assign mem_addr = maddr_q;
  assign mem_wdata = wdat_q;
  assign cpu_entry_swi = swi_q;
  assign cpu_run = run_q;

  // Pin filtering and mode latch
  always_comb begin
    pin_s_d = {pin_s_q[1:0], monitor_serial_pin_in};
    rn_s_d = {rn_s_q[1:0], ext_reset_n};
    ihv_s_d = {ihv_s_q[1:0], irq_high_voltage};
    rhv_s_d = {rhv_s_q[1:0], rst_high_voltage};
    pin_f_d = (pin_s_q[1] == pin_s_q[2]) ? pin_s_q[2] : pin_f_q;
    rn_f_d = (rn_s_q[1] == rn_s_q[2]) ? rn_s_q[2] : rn_f_q;
    ihv_f_d = (ihv_s_q[1] == ihv_s_q[2]) ? ihv_s_q[2] : ihv_f_q;
    rhv_f_d = (rhv_s_q[1] == rhv_s_q[2]) ? rhv_s_q[2] : rhv_f_q;
    mode_d = mode_q;
    div_d = div_q;
    xr_d = 1'b0;
    xdone_d = xdone_q;
    if (!rn_f_q && rn_f_d) begin
      if (ihv_f_q) begin
        mode_d = monitor_pkg::MODE_NORMAL;
        div_d = divisor_select_pin ? monitor_pkg::CLKDIV_4
                                   : monitor_pkg::CLKDIV_2;
      end else if (reset_vector_blank) begin
        mode_d = monitor_pkg::MODE_FORCED;
        div_d = monitor_pkg::CLKDIV_4;
        xr_d = !xdone_q;
        xdone_d = 1'b1;
      end else begin
        mode_d = monitor_pkg::MODE_USER;
        div_d = monitor_pkg::CLKDIV_4;
      end
    end
    unique case (mode_q)
      monitor_pkg::MODE_NORMAL: wd_d = ihv_f_q || rhv_f_q;
      monitor_pkg::MODE_FORCED: wd_d = 1'b1;
      default: wd_d = 1'b0;
    endcase
    dcnt_d = dcnt_q + 2'h1;
    unique case (div_q)
      monitor_pkg::CLKDIV_2: ben_d = dcnt_q[0];
      monitor_pkg::CLKDIV_4: ben_d = dcnt_q == 2'h3;
      default: ben_d = 1'b1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s_q <= 3'h7;
      rn_s_q <= 3'h0;
      ihv_s_q <= 3'h0;
      rhv_s_q <= 3'h0;
      pin_f_q <= 1'b1;
      rn_f_q <= 1'b0;
      ihv_f_q <= 1'b0;
      rhv_f_q <= 1'b0;
      mode_q <= monitor_pkg::MODE_USER;
      div_q <= monitor_pkg::CLKDIV_4;
      dcnt_q <= 2'h0;
      ben_q <= 1'b0;
      wd_q <= 1'b0;
      xr_q <= 1'b0;
      xdone_q <= 1'b0;
    end else begin
      pin_s_q <= pin_s_d;
      rn_s_q <= rn_s_d;
      ihv_s_q <= ihv_s_d;
      rhv_s_q <= rhv_s_d;
      pin_f_q <= pin_f_d;
      rn_f_q <= rn_f_d;
      ihv_f_q <= ihv_f_d;
      rhv_f_q <= rhv_f_d;
      mode_q <= mode_d;
      div_q <= div_d;
      dcnt_q <= dcnt_d;
      ben_q <= ben_d;
      wd_q <= wd_d;
      xr_q <= xr_d;
      xdone_q <= xdone_d;
    end
  end

  // Command engine
  always_comb begin
    st_d = st_q;
    ret_d = ret_q;
    nbytes_d = nbytes_q;
    need_d = need_q;
    cmd_d = cmd_q;
    byte_d = byte_q;
    tx_d = tx_q;
    addr_d = addr_q;
    idx_d = idx_q;
    bits_d = bits_q;
    sec_ok_d = sec_ok_q;
    sec_done_d = sec_done_q;
    tx_go_d = 1'b0;
    tx_brk_d = tx_brk_q;
    mreq_d = 1'b0;
    mwe_d = 1'b0;
    maddr_d = maddr_q;
    wdat_d = wdat_q;
    run_d = 1'b0;
    swi_d = 1'b0;
    ill_d = 1'b0;
    pull_d = uart_pull;
    if (flash_fetch && !sec_ok_q && mode_q != monitor_pkg::MODE_USER) begin
      ill_d = 1'b1;
    end
    if (bit_tick && bits_q != 4'h0) begin
      bits_d = bits_q - 4'h1;
    end
    unique case (st_q)
      S_SEC: begin
        if (sec_done_q || mode_q == monitor_pkg::MODE_USER) begin
          if (sec_done_q && mode_q != monitor_pkg::MODE_USER) begin
            st_d = S_READY;
          end
        end else if (rx_valid) begin
          maddr_d = `MON_SEC_FIRST + {12'h000, nbytes_q};
          mreq_d = 1'b1;
          byte_d = rx_data;
          st_d = S_EXEC;
          ret_d = S_SEC;
        end
      end
      S_READY: begin
        if (tx_busy || tx_go_q) begin
          bits_d = 4'(`MON_ECHO_DELAY_BITS);
        end else if (bits_q == 4'h0) begin
          tx_brk_d = 1'b1;
          tx_go_d = 1'b1;
          swi_d = 1'b1;
          st_d = S_CMD;
        end
      end
      S_CMD: begin
        tx_brk_d = 1'b0;
        nbytes_d = 4'h0;
        if (rx_break) begin
          bits_d = 4'(`MON_BREAK_HIGH_BITS);
          st_d = S_BRKHI;
        end else if (rx_valid) begin
          cmd_d = rx_data;
          need_d = cmd_args(rx_data);
          tx_d = rx_data;
          bits_d = 4'(`MON_ECHO_DELAY_BITS);
          ret_d = (cmd_args(rx_data) == 4'h0) ? S_CANCEL : S_ARG;
          st_d = S_ECHO;
        end
      end
      S_ARG: begin
        if (rx_break) begin
          bits_d = 4'(`MON_BREAK_HIGH_BITS);
          st_d = S_BRKHI;
        end else if (rx_valid) begin
          nbytes_d = nbytes_q + 4'h1;
          tx_d = rx_data;
          if (cmd_q == `MON_CMD_INDEXED_WRITE_CMD || nbytes_q == 4'h2) begin
            wdat_d = rx_data;
          end else begin
            addr_d = {addr_q[7:0], rx_data};
          end
          bits_d = 4'(`MON_ECHO_DELAY_BITS);
          ret_d = (nbytes_q + 4'h1 == need_q) ? S_CANCEL : S_ARG;
          st_d = S_ECHO;
        end
      end
      S_ECHO: begin
        if (tx_busy || tx_go_q) begin
          bits_d = 4'(`MON_ECHO_DELAY_BITS);
        end else if (bits_q == 4'h0) begin
          tx_go_d = 1'b1;
          st_d = ret_q;
          if (ret_q == S_CANCEL) begin
            bits_d = 4'(`MON_CANCEL_BITS);
          end
        end
      end
      S_CANCEL: begin
        if (rx_break) begin
          bits_d = 4'(`MON_BREAK_HIGH_BITS);
          st_d = S_BRKHI;
        end else if (tx_busy || tx_go_q) begin
          bits_d = 4'(`MON_CANCEL_BITS);
        end else if (bits_q == 4'h0) begin
          st_d = S_CMD;
          unique case (cmd_q)
            `MON_CMD_READ, `MON_CMD_INDEXED_READ_CMD: maddr_d = (cmd_q == `MON_CMD_INDEXED_READ_CMD) ? idx_q : addr_q;
            `MON_CMD_STACK_POINTER_READ_CMD: maddr_d = stack_pointer + `MON_SP_READ_OFS;
            `MON_CMD_WRITE: maddr_d = addr_q;
            `MON_CMD_INDEXED_WRITE_CMD: maddr_d = idx_q;
            default: maddr_d = maddr_q;
          endcase
          if (cmd_q == `MON_CMD_RUN) begin
            run_d = 1'b1;
          end else if (cmd_q == `MON_CMD_STACK_POINTER_READ_CMD) begin
            tx_d = maddr_d[15:8];
            bits_d = 4'(`MON_ECHO_DELAY_BITS);
            ret_d = S_DATA;
            st_d = S_ECHO;
          end else if (cmd_q == `MON_CMD_WRITE || cmd_q == `MON_CMD_INDEXED_WRITE_CMD) begin
            mreq_d = 1'b1;
            mwe_d = 1'b1;
            idx_d = maddr_d + 16'h0001;
          end else if (is_read(cmd_q)) begin
            mreq_d = 1'b1;
            idx_d = maddr_d + 16'h0001;
            ret_d = S_DATA;
            st_d = S_EXEC;
          end
        end
      end
      S_EXEC: begin
        if (ret_q == S_SEC) begin
          if (mem_rdata != byte_q) begin
            sec_ok_d = 1'b0;
          end
          nbytes_d = nbytes_q + 4'h1;
          if (nbytes_q == 4'h0) begin
            sec_ok_d = mem_rdata == byte_q;
          end
          tx_d = byte_q;
          bits_d = 4'(`MON_ECHO_DELAY_BITS);
          st_d = S_ECHO;
          if (nbytes_q == 4'(`MON_SEC_COUNT - 1)) begin
            sec_done_d = 1'b1;
          end
        end else begin
          tx_d = (!sec_ok_q && maddr_q[15]) ? `MON_INVALID_DATA : mem_rdata;
          bits_d = 4'(`MON_ECHO_DELAY_BITS);
          st_d = S_ECHO;
        end
      end
      S_DATA: begin
        st_d = S_CMD;
        if (cmd_q == `MON_CMD_STACK_POINTER_READ_CMD && tx_q == maddr_q[15:8]) begin
          tx_d = maddr_q[7:0];
          bits_d = 4'h0;
          ret_d = S_CMD;
          st_d = S_ECHO;
        end
      end
      S_BRKHI: begin
        pull_d = 1'b0;
        if (bits_q == 4'h0) begin
          tx_brk_d = 1'b1;
          tx_go_d = 1'b1;
          st_d = S_BRKTX;
        end
      end
      S_BRKTX: begin
        if (tx_busy) begin
          tx_brk_d = 1'b0;
          st_d = S_CMD;
        end
      end
      default: st_d = S_CMD;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= S_SEC;
      ret_q <= S_SEC;
      nbytes_q <= 4'h0;
      need_q <= 4'h0;
      cmd_q <= 8'h00;
      byte_q <= 8'h00;
      tx_q <= 8'h00;
      addr_q <= 16'h0000;
      idx_q <= 16'h0000;
      bits_q <= 4'h0;
      tx_go_q <= 1'b0;
      tx_brk_q <= 1'b0;
      mreq_q <= 1'b0;
      mwe_q <= 1'b0;
      maddr_q <= 16'h0000;
      wdat_q <= 8'h00;
      run_q <= 1'b0;
      swi_q <= 1'b0;
      ill_q <= 1'b0;
      pull_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ret_q <= ret_d;
      nbytes_q <= nbytes_d;
      need_q <= need_d;
      cmd_q <= cmd_d;
      byte_q <= byte_d;
      tx_q <= tx_d;
      addr_q <= addr_d;
      idx_q <= idx_d;
      bits_q <= bits_d;
      tx_go_q <= tx_go_d;
      tx_brk_q <= tx_brk_d;
      mreq_q <= mreq_d;
      mwe_q <= mwe_d;
      maddr_q <= maddr_d;
      wdat_q <= wdat_d;
      run_q <= run_d;
      swi_q <= swi_d;
      ill_q <= ill_d;
      pull_q <= pull_d;
    end
  end

  // Security state survives non power-on resets
  always_ff @(posedge clk) begin
    if (por) begin
      sec_ok_q <= 1'b0;
      sec_done_q <= 1'b0;
    end else begin
      sec_ok_q <= sec_ok_d;
      sec_done_q <= sec_done_d;
    end
  end
endmodule : monitor_link
`default_nettype wire

// file: shared/monitor_params.svh
`ifndef MONITOR_PARAMS_SVH
`define MONITOR_PARAMS_SVH
`define MON_BAUD_DIV 278
`define MON_ECHO_DELAY_BITS 2
`define MON_BREAK_HIGH_BITS 2
`define MON_CANCEL_BITS 11
`define MON_BREAK_ZEROS 10
`define MON_VEC_RESET_HI 16'hFEFE
`define MON_VEC_RESET_LO 16'hFEFF
`define MON_VEC_SWI_HI 16'hFEFC
`define MON_VEC_SWI_LO 16'hFEFD
`define MON_USER_VEC_PAGE 8'hFF
`define MON_MON_VEC_PAGE 8'hFE
`define MON_SEC_FIRST 16'hFFF6
`define MON_SEC_COUNT 8
`define MON_SEC_FLAG_ADDR 16'h0040
`define MON_SEC_FLAG_BIT 6
`define MON_SP_READ_OFS 16'h0001
`define MON_SP_PCH_OFS 16'h0005
`define MON_SP_PCL_OFS 16'h0006
`define MON_CMD_READ 8'h4A
`define MON_CMD_WRITE 8'h49
`define MON_CMD_INDEXED_READ_CMD 8'h1A
`define MON_CMD_INDEXED_WRITE_CMD 8'h19
`define MON_CMD_STACK_POINTER_READ_CMD 8'h0C
`define MON_CMD_RUN 8'h28
`define MON_INVALID_DATA 8'hAD
`endif

// file: shared/monitor_pkg.sv
package monitor_pkg;
  typedef enum logic [1:0] {
    MODE_USER,
    MODE_NORMAL,
    MODE_FORCED
  } mon_mode_t;
  typedef enum logic [1:0] {
    CLKDIV_1,
    CLKDIV_2,
    CLKDIV_4
  } clk_div_t;
endpackage : monitor_pkg

// file: core/mon_uart.sv
`timescale 1ns/1ps
`default_nettype none
module mon_uart #(
  parameter int DIV = 278
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic bus_en,
  // Filtered line level
  input wire logic line_in,
  // Pull-low request
  output logic pull_low,
  // Receive side
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_break,
  // Transmit side
  input wire logic tx_start,
  input wire logic tx_brk,
  input wire logic [7:0] tx_data,
  output logic tx_busy,
  output logic bit_tick
);
  typedef enum logic [1:0] {R_IDLE, R_START, R_DATA, R_STOP} rx_st_t;
  logic [8:0] bcnt_q, bcnt_d;
  logic [8:0] rcnt_q, rcnt_d;
  rx_st_t rst_q, rst_d;
  logic [3:0] ridx_q, ridx_d;
  logic [8:0] rsh_q, rsh_d;
  logic rv_q, rv_d, rb_q, rb_d;
  logic [3:0] tidx_q, tidx_d;
  logic [9:0] tsh_q, tsh_d;
  logic tb_q, tb_d;
  logic tick;

  assign tick = bus_en && (bcnt_q == 9'(DIV - 1));
  assign pull_low = tb_q && !tsh_q[0];
  assign rx_valid = rv_q;
  assign rx_break = rb_q;
  assign rx_data = rsh_q[7:0];
  assign tx_busy = tb_q;
  assign bit_tick = tick;

  always_comb begin
    bcnt_d = bcnt_q;
    if (bus_en) begin
      bcnt_d = tick ? 9'h000 : bcnt_q + 9'h001;
    end
    rcnt_d = rcnt_q;
    rst_d = rst_q;
    ridx_d = ridx_q;
    rsh_d = rsh_q;
    rv_d = 1'b0;
    rb_d = 1'b0;
    if (bus_en) begin
      rcnt_d = rcnt_q + 9'h001;
      unique case (rst_q)
        R_IDLE: begin
          rcnt_d = 9'h000;
          if (!line_in && !tb_q) begin
            rst_d = R_START;
          end
        end
        R_START: begin
          if (rcnt_q == 9'(DIV / 2)) begin
            rcnt_d = 9'h000;
            rst_d = line_in ? R_IDLE : R_DATA;
            ridx_d = 4'h0;
          end
        end
        R_DATA: begin
          if (rcnt_q == 9'(DIV - 1)) begin
            rcnt_d = 9'h000;
            rsh_d = {line_in, rsh_q[8:1]};
            ridx_d = ridx_q + 4'h1;
            if (ridx_q == 4'h8) begin
              rst_d = R_IDLE;
              if (rsh_q[8:1] == 8'h00 && !line_in) begin
                rb_d = 1'b1;
              end else begin
                rv_d = 1'b1;
              end
              rst_d = R_STOP;
            end
          end
        end
        R_STOP: begin
          if (line_in) begin
            rst_d = R_IDLE;
          end
        end
        default: rst_d = R_IDLE;
      endcase
    end
    tidx_d = tidx_q;
    tsh_d = tsh_q;
    tb_d = tb_q;
    if (!tb_q && tx_start) begin
      tb_d = 1'b1;
      tidx_d = 4'h0;
      tsh_d = tx_brk ? 10'h000 : {1'b1, tx_data, 1'b0};
    end else if (tb_q && tick) begin
      tsh_d = {1'b1, tsh_q[9:1]};
      tidx_d = tidx_q + 4'h1;
      if (tidx_q == 4'h9) begin
        tb_d = 1'b0;
      end
    end
    // Bit timer realigned to each received frame and each transmit start
    if (rv_d || rb_d || (!tb_q && tx_start)) begin
      bcnt_d = 9'h000;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bcnt_q <= 9'h000;
      rcnt_q <= 9'h000;
      rst_q <= R_IDLE;
      ridx_q <= 4'h0;
      rsh_q <= 9'h1FF;
      rv_q <= 1'b0;
      rb_q <= 1'b0;
      tidx_q <= 4'h0;
      tsh_q <= 10'h3FF;
      tb_q <= 1'b0;
    end else begin
      bcnt_q <= bcnt_d;
      rcnt_q <= rcnt_d;
      rst_q <= rst_d;
      ridx_q <= ridx_d;
      rsh_q <= rsh_d;
      rv_q <= rv_d;
      rb_q <= rb_d;
      tidx_q <= tidx_d;
      tsh_q <= tsh_d;
      tb_q <= tb_d;
    end
  end
endmodule : mon_uart
`default_nettype wire

// file: bench/link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module link_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic por,
  // Watched outputs
  input wire logic monitor_serial_pin_out,
  input wire logic bus_clk_en,
  input wire logic [1:0] clk_div_sel,
  input wire logic watchdog_disable,
  input wire logic monitor_active,
  input wire logic extra_reset_req,
  input wire logic [7:0] vector_page,
  input wire logic security_bypassed,
  input wire logic [7:0] security_flag_byte,
  input wire logic flash_read_invalid
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  div2_rate_a: assert property (disable iff (rst || clk_div_sel != 2'd1)
    bus_clk_en |=> !bus_clk_en ##1 bus_clk_en) else $error("bus enable not every 2nd clock");
  div4_rate_a: assert property (disable iff (rst || clk_div_sel != 2'd2)
    bus_clk_en |=> !bus_clk_en [*3] ##1 bus_clk_en) else $error("bus enable not every 4th clock");
  wdog_mode_a: assert property (watchdog_disable |-> monitor_active)
    else $error("watchdog off outside monitor mode");
  extra_pulse_a: assert property (extra_reset_req |=> !extra_reset_req)
    else $error("extra reset longer than one cycle");
  vec_page_a: assert property (monitor_active [*3] |-> vector_page == 8'hFE)
    else $error("vector page not FE in monitor mode");
  sec_keep_a: assert property ($fell(security_bypassed) |-> $past(por))
    else $error("bypass lost without power-on reset");
  flash_inval_a: assert property (flash_read_invalid != security_bypassed)
    else $error("flash invalid flag wrong");
  flag_bit_a: assert property (security_flag_byte[6] == security_bypassed)
    else $error("security flag bit wrong");
  pin_low_a: assert property (monitor_serial_pin_out == 1'b0)
    else $error("link pin driven high");
  cover property ($rose(security_bypassed));
  cover property (bus_clk_en && clk_div_sel == 2'd1);
  cover property (extra_reset_req);
endmodule : link_asserts
bind monitor_link link_asserts link_asserts_inst (.clk(clk), .rst(rst), .por(por),
  .monitor_serial_pin_out(monitor_serial_pin_out), .bus_clk_en(bus_clk_en),
  .clk_div_sel(clk_div_sel), .watchdog_disable(watchdog_disable),
  .monitor_active(monitor_active), .extra_reset_req(extra_reset_req),
  .vector_page(vector_page), .security_bypassed(security_bypassed),
  .security_flag_byte(security_flag_byte), .flash_read_invalid(flash_read_invalid));
`default_nettype wire

// file: bench/host_link.sv
`timescale 1ns/1ps
`default_nettype none
module host_link #(
  parameter int BIT = 64
) (
  // Link
  input wire logic clk,
  input wire logic line,
  output logic oe
);
  initial oe = 1'b0;
  // Start low, data LSB first, then stop
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      oe = !f[i];
      repeat (BIT) @(negedge clk);
    end
    oe = 1'b0;
  endtask : send
  // Mid-bit sampling; v[8] is the stop level
  task automatic recv(output logic [8:0] v, output int gap);
    gap = 0;
    v = 9'h1FF;
    while (line !== 1'b1 && gap < 40 * BIT) begin
      @(negedge clk);
      gap++;
    end
    gap = 0;
    while (line !== 1'b0 && gap < 40 * BIT) begin
      @(negedge clk);
      gap++;
    end
    repeat (BIT / 2) @(negedge clk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT) @(negedge clk);
      v[i] = line;
    end
    repeat (BIT / 2) @(negedge clk);
  endtask : recv
endmodule : host_link
`default_nettype wire

// file: bench/tb_monitor_link.sv
`timescale 1ns/1ps
`default_nettype none
module tb_monitor_link;
  localparam int DIV = 16;
  localparam int BIT = DIV * 4;
  logic clk, rst, por, ext_n, irq_hv, rst_hv, div_pin, blank;
  logic oe, line, host_oe, mem_req, mem_we, wdog, bypassed, inval;
  logic [15:0] mem_addr, wr_addr;
  logic [7:0] mem_wdata, mem_rdata, wr_data, flag_byte, page;
  logic [1:0] div_sel;
  logic [8:0] v;
  int gap, errors, compares;
  assign line = !(oe | host_oe);
  monitor_link #(.BAUD_DIV(DIV)) monitor_link_inst (.clk(clk), .rst(rst), .por(por),
    .ext_reset_n(ext_n), .irq_high_voltage(irq_hv), .rst_high_voltage(rst_hv),
    .divisor_select_pin(div_pin), .reset_vector_blank(blank),
    .monitor_serial_pin_in(line), .monitor_serial_pin_out(), .monitor_serial_pin_oe(oe),
    .bus_clk_en(), .clk_div_sel(div_sel), .watchdog_disable(wdog), .monitor_active(),
    .extra_reset_req(), .vector_page(page), .security_bypassed(bypassed),
    .security_flag_byte(flag_byte), .flash_read_invalid(inval), .flash_fetch(1'b0),
    .illegal_addr_reset(), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .stack_pointer(16'h12F0),
    .cpu_entry_swi(), .cpu_run());
  host_link #(.BIT(BIT)) host_link_inst (.clk(clk), .line(line), .oe(host_oe));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Memory: reads return low address byte plus 0x11, writes captured
  always @(negedge clk) begin
    if (mem_req && !mem_we) mem_rdata <= mem_addr[7:0] + 8'h11;
    if (mem_req && mem_we) begin
      wr_addr <= mem_addr;
      wr_data <= mem_wdata;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic do_reset(input logic p, input logic hv, input logic ds, input logic bl);
    @(negedge clk);
    rst = 1'b1;
    por = p;
    ext_n = 1'b0;
    irq_hv = hv;
    div_pin = ds;
    blank = bl;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    por = 1'b0;
    repeat (4) @(negedge clk);
    ext_n = 1'b1;
    repeat (20) @(negedge clk);
  endtask : do_reset
  task automatic put(input logic [7:0] b);
    host_link_inst.send(b, 1'b1);
    host_link_inst.recv(v, gap);
    chk(16'(v), {7'h00, 1'b1, b});
    chk(16'(gap >= BIT && gap <= 3 * BIT), 16'h0001);
    repeat (BIT) @(negedge clk);
  endtask : put
  task automatic get(input logic [8:0] exp);
    host_link_inst.recv(v, gap);
    chk(16'(v), 16'(exp));
  endtask : get
  task automatic t_entry();
    chk(16'(div_sel), 16'h0002);
    chk(16'(page), 16'h00FE);
    chk(16'(wdog), 16'h0001);
  endtask : t_entry
  task automatic t_secure();
    for (int n = 0; n < 8; n++) put(8'h07 + 8'(n));
    get(9'h000);
    chk(16'(bypassed), 16'h0001);
    chk(16'(flag_byte[6]), 16'h0001);
    chk(16'(inval), 16'h0000);
  endtask : t_secure
  task automatic t_read();
    put(8'h4A);
    put(8'hFF);
    put(8'h20);
    get(9'h131);
    put(8'h1A);
    get(9'h132);
    put(8'h0C);
    get(9'h112);
    get(9'h1F1);
  endtask : t_read
  task automatic t_write();
    put(8'h49);
    put(8'h00);
    put(8'h80);
    put(8'h5C);
    repeat (16 * BIT) @(negedge clk);
    chk(wr_addr, 16'h0080);
    chk(16'(wr_data), 16'h005C);
    put(8'h19);
    put(8'hA7);
    repeat (16 * BIT) @(negedge clk);
    chk(wr_addr, 16'h0081);
  endtask : t_write
  task automatic t_cancel();
    put(8'h49);
    put(8'h00);
    put(8'h90);
    host_link_inst.send(8'h33, 1'b1);
    host_link_inst.recv(v, gap);
    host_link_inst.send(8'h00, 1'b0);
    get(9'h000);
    repeat (16 * BIT) @(negedge clk);
    chk(wr_addr, 16'h0081);
  endtask : t_cancel
  task automatic t_wdog();
    rst_hv = 1'b1;
    irq_hv = 1'b0;
    repeat (10) @(negedge clk);
    chk(16'(wdog), 16'h0001);
    rst_hv = 1'b0;
    repeat (10) @(negedge clk);
    chk(16'(wdog), 16'h0000);
  endtask : t_wdog
  task automatic t_modes();
    do_reset(1'b0, 1'b1, 1'b0, 1'b0);
    chk(16'(div_sel), 16'h0001);
    chk(16'(bypassed), 16'h0001);
    do_reset(1'b0, 1'b0, 1'b0, 1'b1);
    chk(16'(div_sel), 16'h0002);
    chk(16'(wdog), 16'h0001);
  endtask : t_modes
  task automatic end_sim();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    errors = 0;
    compares = 0;
    rst = 1'b1;
    por = 1'b1;
    ext_n = 1'b0;
    irq_hv = 1'b1;
    rst_hv = 1'b0;
    div_pin = 1'b1;
    blank = 1'b0;
    mem_rdata = 8'h00;
    do_reset(1'b1, 1'b1, 1'b1, 1'b0);
    t_entry();
    t_secure();
    t_read();
    t_write();
    t_cancel();
    t_wdog();
    t_modes();
    end_sim();
  end
  initial begin
    repeat (95000) @(posedge clk);
    errors++;
    end_sim();
  end
endmodule : tb_monitor_link
`default_nettype wire
